// File: bench/lsfp_host.sv
// host model driving the register port of the block
`timescale 1ns/10ps
module lsfp_host (
  // clock
  input  wire logic       mclk_i,
  // register port
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  // idle bus, strobes low from time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // one write; address inverted on release so no stale value lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  // one read; registered data stands from the read edge itself, sampled two negedges later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge mclk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    @(negedge mclk_i);
    d = reg_rdata_i;
  endtask : rd
endmodule : lsfp_host

// File: bench/tb_top.sv
// self-checking bench for the led string fault protection block
`timescale 1ns/10ps
module tb_top;
  import lsfp_pkg::*;
  localparam int unsigned TO_CYC = 200;
  localparam int unsigned HOT_CYC = 50;
  logic           mclk = 1'b0;
  logic           resetn = 1'b0;
  logic           wr, rd, gate, thr_hi, chop;
  logic [7:0]     addr, wdata, rdata, d;
  logic [NCH-1:0] ch_en;
  logic [3:0]     ilim;
  lsfp_sense_t    sense = '0;
  logic           ext_dim = 1'b0;
  logic           ext_mode = 1'b1;
  logic           int_osc = 1'b0;
  int             fail_count = 0;
  int             cmp_count = 0;
  int             cyc = 0;
  int             n;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  lsfp_core #(.OPEN_TO_CYC(TO_CYC), .OPEN_HOT_CYC(HOT_CYC)) i_lsfp_core (
    .mclk_i(mclk), .resetn_i(resetn), .ce_i(1'b1),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .sense_i(sense), .ext_dim_input_i(ext_dim),
    .int_dim_osc_i(int_osc), .ext_mode_i(ext_mode), .ch_enable_o(ch_en),
    .boost_gate_o(gate), .ilim_step_o(ilim), .sc_thr_high_o(thr_hi),
    .dim_chop_o(chop));
  lsfp_host i_lsfp_host (
    .mclk_i(mclk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int c);
    repeat (c) @(negedge mclk);
  endtask : wt
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // hang guard, well above the soft-start length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    chk(ch_en, 8'hFF);
    i_lsfp_host.rd(ADDR_CONFIG, d);
    chk(d & 8'h05, 8'h05);
    chk(thr_hi, 1'b1);
    chk(gate, 1'b0);
    chk(ilim, 4'h0);
  endtask : t_defaults
  // limit steps once per eighth of 1ms, then a hit cuts the gate to one cycle per switching period
  task automatic t_soft();
    sense.fet_on = 1'b1;
    sense.stable = 1'b1;
    wt(8);
    chk(ilim, 4'h0);
    for (int k = 1; k < 8; k++) begin
      wt(SS_STEP_CYC);
      chk(ilim, 4'(k));
    end
    wt(SS_STEP_CYC);
    sense.sw_ocl = 1'b1;
    wt(6);
    n = 0;
    repeat (40) begin
      wt(1);
      n += int'(gate);
    end
    chk(8'(n), 8'h02);
    sense.sw_ocl = 1'b0;
    wt(26);
    n = 0;
    repeat (40) begin
      wt(1);
      n += int'(gate);
    end
    chk(8'(n), 8'h14);
  endtask : t_soft
  ////////////////////////////////////////////////////////////////////////
  task automatic t_short();
    sense.above_sc_lo = 8'h44;
    sense.above_sc_hi = 8'h04;
    sense.stable = 1'b0;
    i_lsfp_host.wr(ADDR_CONFIG, 8'h05);
    wt(10);
    chk(ch_en[2], 1'b1);
    i_lsfp_host.wr(ADDR_CONFIG, 8'h07);
    sense.stable = 1'b1;
    wt(10);
    chk(ch_en[2], 1'b1);
    i_lsfp_host.wr(ADDR_CONFIG, 8'h05);
    wt(10);
    chk(ch_en[2], 1'b0);
    chk(ch_en[6], 1'b1);
    i_lsfp_host.wr(ADDR_CONFIG, 8'h04);
    wt(10);
    chk(thr_hi, 1'b0);
    chk(ch_en[6], 1'b0);
    i_lsfp_host.rd(ADDR_FAULT, d);
    chk(d[FLT_SHORT], 1'b1);
    i_lsfp_host.rd(ADDR_MASK, d);
    chk(d & 8'h44, 8'h44);
    i_lsfp_host.wr(ADDR_MASK, 8'h01);
    wt(4);
    chk(ch_en[0], 1'b0);
  endtask : t_short
  // good channel drops out late; hot sweep is quicker
  task automatic t_open();
    sense.cur_ge75 = 8'h82;
    wt(8);
    sense.cur_lt50 = 8'h02;
    wt(10);
    chk(ch_en[1], 1'b1);
    wt(TO_CYC);
    chk(ch_en[1], 1'b0);
    i_lsfp_host.rd(ADDR_FAULT, d);
    chk(d[FLT_OPEN], 1'b1);
    sense.ot_low = 1'b1;
    wt(HOT_CYC + 10);
    chk(ch_en[5], 1'b0);
    chk(ch_en[7], 1'b1);
  endtask : t_open
  // overvoltage and heat are logged; a good string stays lit
  task automatic t_therm();
    sense.overvoltage_limit = 1'b1;
    sense.ot_high = 1'b1;
    wt(6);
    chk(ch_en[7], 1'b1);
    i_lsfp_host.rd(ADDR_FAULT, d);
    chk(d[FLT_THERM], 1'b1);
    chk(d[FLT_OVP], 1'b1);
  endtask : t_therm
  task automatic t_ocp();
    ext_dim = 1'b1;
    wt(6);
    chk(chop, 1'b1);
    ext_dim = 1'b0;
    wt(6);
    chk(chop, 1'b0);
    ext_mode = 1'b0;
    int_osc = 1'b1;
    ext_dim = 1'b1;
    wt(6);
    chk(chop, 1'b1);
    int_osc = 1'b0;
    wt(6);
    chk(chop, 1'b0);
    sense.in_ocp = 1'b1;
    wt(8);
    chk(ch_en, 8'h00);
    i_lsfp_host.rd(ADDR_FAULT, d);
    chk(d[FLT_OCP], 1'b1);
  endtask : t_ocp
  // main sequence
  initial begin
    wt(8);
    resetn = 1'b1;
    wt(2);
    t_defaults();
    t_soft();
    t_short();
    t_open();
    t_therm();
    t_ocp();
    give_verdict();
  end
endmodule : tb_top

// File: logic/lsfp_core.sv
// protection and monitoring logic of the eight string led driver
`timescale 1ns/10ps
module lsfp_core
  import lsfp_pkg::*;
#(
  parameter int unsigned OPEN_TO_CYC  = (OPEN_TO_US * CLK_KHZ) / 1000,
  parameter int unsigned OPEN_HOT_CYC = (OPEN_HOT_US * CLK_KHZ) / 1000
) (
  // clock, reset, enable
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  // register port
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  // analog comparator pins
  input  wire lsfp_sense_t      sense_i,
  input  wire logic             ext_dim_input_i,
  input  wire logic             int_dim_osc_i,
  input  wire logic             ext_mode_i,
  // outputs to power stage
  output logic [NCH-1:0]        ch_enable_o,
  output logic                  boost_gate_o,
  output logic [3:0]            ilim_step_o,
  output logic                  sc_thr_high_o,
  output logic                  dim_chop_o
);

  typedef enum logic [2:0] {
    S_INRUSH = 3'b001,
    S_SOFT   = 3'b010,
    S_RUN    = 3'b100
  } lsfp_st_t;

  typedef struct packed {
    lsfp_sense_t     s1;
    lsfp_sense_t     s2;
    logic [2:0]      d1;
    logic [2:0]      d2;
    lsfp_st_t        st;
    logic [7:0]      cfg;
    logic [7:0]      mask;
    logic [7:0]      fault;
    logic [NCH-1:0]  good;
    logic [NCH-1:0]  open;
    logic [NCH-1:0]  off;
    logic [NCH*CW-1:0] tmr;
    logic [TW-1:0]   sw_cnt;
    logic            sw_kill;
    logic [15:0]     ss_cnt;
    logic [3:0]      ilim;
    logic            ocp_off;
    logic            oth_d;
    logic [7:0]      rdata;
    logic [NCH-1:0]  en;
    logic            gate;
    logic            chop;
  } lsfp_state_t;

  lsfp_state_t q_r, q_nxt;

  logic [NCH-1:0] sc_hit;
  logic [TW-1:0]  sw_per;
  logic [CW-1:0]  to_lim;

  ////////////////////////////////////////////////////////////////////////
  // per channel short, open and time-out logic
  assign sw_per = q_r.cfg[CFG_FSW] ? TW'(SW_DIV_HI) : TW'(SW_DIV_LO);
  // shorter limit above 130 degrees to keep clear of thermal trip
  assign to_lim = q_r.s2.ot_low ? CW'(OPEN_HOT_CYC)
                                : CW'(OPEN_TO_CYC);

  always_comb begin
    q_nxt = q_r;
    // synchronisers: second stage only feeds logic
    q_nxt.s1 = sense_i;
    q_nxt.s2 = q_r.s1;
    q_nxt.d1 = {ext_dim_input_i, int_dim_osc_i, ext_mode_i};
    q_nxt.d2 = q_r.d1;
    sc_hit   = q_r.cfg[CFG_SCTHR] ? q_r.s2.above_sc_hi
                                  : q_r.s2.above_sc_lo;
    for (int i = 0; i < NCH; i++) begin
      if (!q_r.mask[i] && !q_r.off[i] && q_r.st == S_RUN
          && q_r.s2.stable) begin
        if (!q_r.cfg[CFG_SCDIS] && sc_hit[i]) begin
          q_nxt.off[i] = 1'b1;
          q_nxt.fault[FLT_SHORT] = 1'b1;
        end
        if (q_r.s2.cur_ge75[i])
          q_nxt.good[i] = 1'b1;
        if (q_r.good[i] && q_r.s2.cur_lt50[i])
          q_nxt.open[i] = 1'b1;
        // zener strings reach here through overvoltage or the lower overtemp threshold
        if (!q_r.good[i] && (q_r.s2.overvoltage_limit || q_r.s2.ot_low))
          q_nxt.open[i] = 1'b1;
      end
      if (q_r.open[i] && !q_r.off[i]) begin
        if (q_r.tmr[i*CW +: CW] >= to_lim) begin
          q_nxt.off[i] = 1'b1;
          q_nxt.fault[FLT_OPEN] = 1'b1;
        end else begin
          q_nxt.tmr[i*CW +: CW] = q_r.tmr[i*CW +: CW] + CW'(1);
        end
      end
    end
    if (q_r.s2.overvoltage_limit)
      q_nxt.fault[FLT_OVP] = 1'b1;
    if (q_r.s2.ot_low)
      q_nxt.fault[FLT_LOTEMP] = 1'b1;
    q_nxt.oth_d = q_r.s2.ot_high;
    if (q_r.s2.ot_high && !q_r.oth_d)
      q_nxt.fault[FLT_THERM] = 1'b1;
    if (q_r.s2.in_ocp) begin
      q_nxt.ocp_off = 1'b1;
      q_nxt.fault[FLT_OCP] = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////
    // inrush, soft-start and cycle by cycle limit
    unique case (q_r.st)
      S_INRUSH: begin
        q_nxt.ilim = 4'h0;
        if (q_r.s2.fet_on) begin
          q_nxt.st = S_SOFT;
          q_nxt.ss_cnt = 16'h0000;
        end
      end
      S_SOFT: begin
        if (q_r.ss_cnt == 16'(SS_STEP_CYC - 1)) begin
          q_nxt.ss_cnt = 16'h0000;
          if (q_r.ilim == 4'(SS_STEPS - 1))
            q_nxt.st = S_RUN;
          else
            q_nxt.ilim = q_r.ilim + 4'h1;
        end else begin
          q_nxt.ss_cnt = q_r.ss_cnt + 16'h0001;
        end
      end
      S_RUN: q_nxt.ilim = 4'(SS_STEPS - 1);
    endcase
    if (q_r.sw_cnt >= sw_per - TW'(1)) begin
      q_nxt.sw_cnt = '0;
      q_nxt.sw_kill = 1'b0;
    end else begin
      q_nxt.sw_cnt = q_r.sw_cnt + TW'(1);
    end
    if (q_r.gate && q_r.s2.sw_ocl)
      q_nxt.sw_kill = 1'b1;
    q_nxt.gate = q_r.st != S_INRUSH && !q_r.ocp_off && !q_nxt.sw_kill
                 && q_nxt.sw_cnt < (sw_per >> 1);

    // chop follows external input only in external mode
    q_nxt.chop = q_r.d2[0] ? q_r.d2[2] : q_r.d2[1];

    //////////////////////////////////////////////////////////////////////
    // register access, channel faults see the mask from before a host write
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CONFIG)
        q_nxt.cfg = reg_wdata_i;
      if (reg_addr_i == ADDR_MASK)
        q_nxt.mask = reg_wdata_i;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_FAULT:  q_nxt.rdata = q_r.fault;
        ADDR_CONFIG: q_nxt.rdata = q_r.cfg;
        ADDR_MASK:   q_nxt.rdata = q_r.mask | q_r.off;
        default:     q_nxt.rdata = 8'h00;
      endcase
    end
    q_nxt.en = q_r.ocp_off ? '0 : ~(q_nxt.mask | q_nxt.off);
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_r      <= '0;
      q_r.st   <= S_INRUSH;
      q_r.cfg  <= CONFIG_RST;
      q_r.mask <= MASK_RST;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata_o   = q_r.rdata;
  assign ch_enable_o   = q_r.en;
  assign boost_gate_o  = q_r.gate;
  assign ilim_step_o   = q_r.ilim;
  assign sc_thr_high_o = q_r.cfg[CFG_SCTHR];
  assign dim_chop_o    = q_r.chop;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  // every channel dark once input overcurrent has latched
  a_ocp_all_off: assert property (
    ce_i && q_r.ocp_off |=> ch_enable_o == '0)
    else $error("channels on after overcurrent");
  // cause of the shutdown kept for the host
  a_ocp_latch: assert property (
    ce_i && q_r.s2.in_ocp |=> q_r.fault[FLT_OCP])
    else $error("overcurrent cause not latched");
  // no switching until the protection transistor is hard on
  a_no_gate_inrush: assert property (
    q_r.st == S_INRUSH |-> !boost_gate_o)
    else $error("switching during inrush");
  // a masked channel never lights, whatever the fault state
  a_mask_off: assert property (
    (ch_enable_o & q_r.mask) == '0)
    else $error("masked channel enabled");
  // soft-start step never runs past the 3A level
  a_ilim_max: assert property (
    ilim_step_o <= 4'(SS_STEPS - 1))
    else $error("limit step out of range");
  // a killed cycle keeps the switch off until the next period
  a_gate_kill: assert property (
    q_r.sw_kill |-> !boost_gate_o)
    else $error("gate on after overcurrent cycle");
  // each hit of the upper limit is logged
  a_therm_set: assert property (
    ce_i && q_r.s2.ot_high && !q_r.oth_d |=> q_r.fault[FLT_THERM])
    else $error("thermal bit not set");
  // detection alone never cuts a channel
  a_open_wait: assert property (
    ce_i && $rose(q_r.open[1]) && !q_r.off[1]
    |=> !q_r.off[1] || q_r.mask[1] || sc_hit[1])
    else $error("open channel cut without time-out");
  // fault bits are sticky until reset
  a_fault_keep: assert property (
    q_r.fault[FLT_SHORT] |=> q_r.fault[FLT_SHORT])
    else $error("short fault lost");
  a_open_keep: assert property (
    q_r.fault[FLT_OPEN] |=> q_r.fault[FLT_OPEN])
    else $error("open fault lost");
  // channels above the threshold are cut at once
  a_short_cut: assert property (
    ce_i && q_r.st == S_RUN && q_r.s2.stable && !q_r.cfg[CFG_SCDIS]
    |=> ($past(sc_hit & ~q_r.mask) & ~q_r.off) == '0)
    else $error("shorted channel left on");
  // disabled detection never raises a short fault
  a_short_dis: assert property (
    ce_i && q_r.cfg[CFG_SCDIS] && !q_r.fault[FLT_SHORT]
    |=> !q_r.fault[FLT_SHORT])
    else $error("short fault while detection off");
  // 75 percent current marks the string good
  a_good_set: assert property (
    ce_i && q_r.st == S_RUN && q_r.s2.stable && q_r.s2.cur_ge75[1]
    && !q_r.mask[1] && !q_r.off[1] |=> q_r.good[1])
    else $error("good string not marked");
  a_good_keep: assert property (
    q_r.good[1] |=> q_r.good[1])
    else $error("good mark lost");
  // a good string that sags below half is open
  a_open_set: assert property (
    ce_i && q_r.st == S_RUN && q_r.s2.stable && q_r.good[1]
    && q_r.s2.cur_lt50[1] && !q_r.mask[1] && !q_r.off[1]
    |=> q_r.open[1])
    else $error("sagging string not open");
  // hot sweep marks every string not yet good
  a_sweep_open: assert property (
    ce_i && q_r.st == S_RUN && q_r.s2.stable && q_r.s2.ot_low
    && !q_r.good[3] && !q_r.mask[3] && !q_r.off[3] |=> q_r.open[3])
    else $error("sweep missed a string");
  // transients while unsettled never move the classification
  a_unstable_hold: assert property (
    ce_i && !q_r.s2.stable
    |=> q_r.good == $past(q_r.good) && q_r.open == $past(q_r.open))
    else $error("classification moved while unstable");
  // expired time-out cuts the string and logs it
  a_to_expire: assert property (
    ce_i && q_r.open[1] && !q_r.off[1]
    && q_r.tmr[1*CW +: CW] >= to_lim
    |=> q_r.off[1] && q_r.fault[FLT_OPEN])
    else $error("time-out did not cut string");
  // short limit applies above the lower threshold
  a_hot_limit: assert property (
    ce_i && q_r.s2.ot_low && q_r.open[3] && !q_r.off[3]
    && q_r.tmr[3*CW +: CW] >= CW'(OPEN_HOT_CYC) |=> q_r.off[3])
    else $error("hot time-out not shortened");
  a_lotemp_flag: assert property (
    ce_i && q_r.s2.ot_low |=> q_r.fault[FLT_LOTEMP])
    else $error("lower threshold not logged");
  a_ovp_flag: assert property (
    ce_i && q_r.s2.overvoltage_limit |=> q_r.fault[FLT_OVP])
    else $error("overvoltage not logged");
  // limit only moves at the end of a step interval
  a_step_once: assert property (
    ce_i && q_r.st == S_SOFT && q_r.ss_cnt != 16'(SS_STEP_CYC - 1)
    |=> $stable(ilim_step_o))
    else $error("limit stepped early");
  a_ilim_run: assert property (
    q_r.st == S_RUN |-> ilim_step_o == 4'(SS_STEPS - 1))
    else $error("run without full limit");
  a_inrush_ilim: assert property (
    q_r.st == S_INRUSH |-> ilim_step_o == 4'h0)
    else $error("limit above first step in inrush");
  a_run_stay: assert property (
    q_r.st == S_RUN |=> q_r.st == S_RUN)
    else $error("left run state");
  a_fet_wait: assert property (
    ce_i && q_r.st == S_INRUSH && !q_r.s2.fet_on |=> q_r.st == S_INRUSH)
    else $error("soft-start before transistor on");
  // switching period wraps at the selected divider
  a_fsw_wrap: assert property (
    ce_i && q_r.sw_cnt == sw_per - TW'(1) |=> q_r.sw_cnt == '0)
    else $error("switching period wrong");
  a_ocl_kill: assert property (
    ce_i && q_r.gate && q_r.s2.sw_ocl |=> !boost_gate_o)
    else $error("cycle not terminated at limit");
  a_gate_ocp: assert property (
    q_r.ocp_off |=> !boost_gate_o)
    else $error("switching after overcurrent");
  a_ocp_stay: assert property (
    q_r.ocp_off |=> q_r.ocp_off)
    else $error("overcurrent shutdown released");
  // enables track mask and cut strings
  a_en_track: assert property (
    ce_i && !q_r.ocp_off |=> ch_enable_o == ~(q_r.mask | q_r.off))
    else $error("enables out of step");
  a_mask_keep: assert property (
    ce_i && q_r.mask[0] && !q_r.off[0] && !q_r.open[0] |=> !q_r.off[0])
    else $error("masked channel faulted");
  // register port: writes land, reads hold
  a_wr_cfg: assert property (
    ce_i && reg_wr_i && reg_addr_i == ADDR_CONFIG
    |=> q_r.cfg == $past(reg_wdata_i))
    else $error("config write lost");
  a_wr_mask: assert property (
    ce_i && reg_wr_i && reg_addr_i == ADDR_MASK
    |=> q_r.mask == $past(reg_wdata_i))
    else $error("mask write lost");
  a_fault_read: assert property (
    ce_i && reg_rd_i && reg_addr_i == ADDR_FAULT
    |=> reg_rdata_o == $past(q_r.fault))
    else $error("fault read wrong");
  a_mask_read: assert property (
    ce_i && reg_rd_i && reg_addr_i == ADDR_MASK
    |=> reg_rdata_o == $past(q_r.mask | q_r.off))
    else $error("mask read wrong");
  a_cfg_read: assert property (
    ce_i && reg_rd_i && reg_addr_i == ADDR_CONFIG
    |=> reg_rdata_o == $past(q_r.cfg))
    else $error("config read wrong");
  a_rdata_hold: assert property (
    !reg_rd_i || !ce_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  // chop source by mode
  a_chop_ext: assert property (
    ce_i && q_r.d2[0] |=> dim_chop_o == $past(q_r.d2[2]))
    else $error("chop not following input");
  a_chop_int: assert property (
    ce_i && !q_r.d2[0] |=> dim_chop_o == $past(q_r.d2[1]))
    else $error("chop not following oscillator");
  c_soft_done: cover property (q_r.st == S_SOFT ##1 q_r.st == S_RUN);
  c_open_off: cover property ($rose(q_r.off[1]) && q_r.open[1]);
  c_short_off: cover property ($rose(q_r.fault[FLT_SHORT]));
  c_ocp: cover property ($rose(q_r.ocp_off));
  c_hot_off: cover property ($rose(q_r.off[3]) && q_r.s2.ot_low);

endmodule : lsfp_core

// File: logic/lsfp_pkg.sv
// constants and types for the led string fault protection block
// Operation
// - boost clock 600kHz or 1.2MHz by config bit 2, default 1.2MHz
// - short threshold 3.1V or 8.0V by config bit 0, default 8V
// - config bit 1 set switches off short detection
// - channel above short threshold is flagged faulty and disabled
// - channel is good once current reaches 75% of target
// - good channel falling below 50% of target is open circuit
// - overvoltage or lower overtemp marks all not-good channels open
// - open channel disabled only after time-out expires
// - open time-out shortened above lower overtemp threshold
// - soft-start limit 375mA then 7 steps of 375mA to 3A in 1ms
// - no switching until protection transistor is fully on
// - switching cycle ends when switch current exceeds limit
// - every led fault recorded in fault status register 0x02
// - masking register 0x09 shows failed channels
// - host masks bad channels at start; they stay off, unreported
// - led channel faults ignored while operation is not stable
// - input overcurrent switches off all channels, logic stays alive
// - shutdown cause latched into fault status register
// - zener-bypassed string stays on unless overvoltage or lower overtemp reached
// - external mode chops at input rate, else internal oscillator
// - lower overtemp threshold sits at 130 degrees
// - upper thermal limit sets thermal fault bit in 0x02
package lsfp_pkg;
  localparam int unsigned NCH = 8;
  localparam logic [7:0] ADDR_FAULT   = 8'h02;
  localparam logic [7:0] ADDR_CONFIG  = 8'h08;
  localparam logic [7:0] ADDR_MASK    = 8'h09;
  localparam logic [7:0] CONFIG_RST   = 8'h05;  // 8V, detect on, 1.2MHz
  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam int unsigned CFG_SCTHR   = 0;
  localparam int unsigned CFG_SCDIS   = 1;
  localparam int unsigned CFG_FSW     = 2;
  localparam int unsigned FLT_SHORT   = 0;
  localparam int unsigned FLT_OPEN    = 1;
  localparam int unsigned FLT_OVP     = 2;
  localparam int unsigned FLT_OCP     = 3;
  localparam int unsigned FLT_THERM   = 4;
  localparam int unsigned FLT_LOTEMP  = 5;
  // timing, clock 25 MHz
  localparam int unsigned CLK_KHZ     = 25000;
  localparam int unsigned FSW_HI_KHZ  = 1200;
  localparam int unsigned FSW_LO_KHZ  = 600;
  localparam int unsigned SW_DIV_HI   = CLK_KHZ / FSW_HI_KHZ;
  localparam int unsigned SW_DIV_LO   = CLK_KHZ / FSW_LO_KHZ;
  localparam int unsigned SS_TOTAL_US = 1000;
  localparam int unsigned SS_STEPS    = 8;
  localparam int unsigned SS_STEP_CYC =
    (SS_TOTAL_US * (CLK_KHZ / 1000)) / SS_STEPS;
  localparam int unsigned ILIM_STEP_MA = 375;
  localparam int unsigned OPEN_TO_US  = 6000;
  localparam int unsigned OPEN_HOT_US = 800;
  localparam int unsigned OT_LOW_DEGC = 130;
  localparam int unsigned SETTLE_CYC  = 16;
  localparam int unsigned CW = 18;
  localparam int unsigned TW = 8;

  typedef struct packed {
    logic [NCH-1:0] above_sc_lo;  // channel above 3.1V
    logic [NCH-1:0] above_sc_hi;  // channel above 8.0V
    logic [NCH-1:0] cur_ge75;
    logic [NCH-1:0] cur_lt50;
    logic           overvoltage_limit;
    logic           ot_low;
    logic           ot_high;
    logic           in_ocp;
    logic           fet_on;
    logic           sw_ocl;
    logic           stable;
  } lsfp_sense_t;
endpackage : lsfp_pkg
